// ### cfab_core.sv
// CPU flags register, accumulator and bank-steered register-space decode.
//
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "cfab_regs.svh"

module cfab_core
  import cfab_pkg::*;
(
  // Clock and reset.
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  // AHB-Lite slave.
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Execution unit.
  input  wire cfab_exec_s  EXEC,
  input  wire logic        SUPER_MODE,
  output logic      [7:0]  ACC,
  // Register space.
  input  wire logic        RS_VALID,
  input  wire logic [7:0]  RS_ADDR,
  input  wire logic        RS_WRITE,
  output cfab_rsel_s       RS_SEL,
  // Interrupt gate.
  input  wire logic        IRQ_REQ,
  output logic             IRQ_OUT
);

  ////////////////////////////////////////////////////////////////////////////////
  // Storage.

  logic [7:0] flags_ff;      // Flags register.
  logic [7:0] acc_ff;        // Accumulator.
  logic [7:0] nxt_acc;       // Next accumulator value.
  logic       nxt_carry;     // Carry of the current operation.
  logic       alu_go;        // Current request is a logical/arithmetic op.
  logic       ph_valid_ff;   // Bus data phase pending.
  logic       ph_write_ff;   // Pending phase is a write.
  logic [31:0] ph_addr_ff;   // Pending phase address.
  logic [31:0] rdata_ff;     // Registered read data.
  logic [7:0] nxt_flags;     // Flags after the requested flag instruction.

  // Applies a logical flag instruction to the writable flag bits.
  function automatic logic [7:0] flag_logic(input logic [7:0] f, input cfab_fop_e k, input logic [7:0] m);
    logic [7:0] r;
    r = f;
    case (k)
      CFAB_FOP_AND: r = f & m;
      CFAB_FOP_OR:  r = f | m;
      CFAB_FOP_XOR: r = f ^ m;
      default:      r = f;
    endcase
    return (f & ~`CFAB_FLAGS_RW_MASK) | (r & `CFAB_FLAGS_RW_MASK);
  endfunction : flag_logic

  // Computed once here so that the update below can pick single bits from the result.
  assign nxt_flags = flag_logic(flags_ff, EXEC.fop, EXEC.fmask);

  ////////////////////////////////////////////////////////////////////////////////
  // Arithmetic and logic unit.

  // Result and carry for the requested operation; carry is the adder carry-out for an addition, the borrow for a subtraction, zero otherwise.
  always_comb
  begin
    nxt_acc   = acc_ff;
    nxt_carry = 1'b0;
    alu_go    = EXEC.valid;
    case (EXEC.op)
      CFAB_OP_AND: nxt_acc = acc_ff & EXEC.operand;
      CFAB_OP_OR:  nxt_acc = acc_ff | EXEC.operand;
      CFAB_OP_XOR: nxt_acc = acc_ff ^ EXEC.operand;
      CFAB_OP_ADD: {nxt_carry, nxt_acc} = {1'b0, acc_ff} + {1'b0, EXEC.operand};
      CFAB_OP_SUB: {nxt_carry, nxt_acc} = {1'b0, acc_ff} - {1'b0, EXEC.operand};
      CFAB_OP_MOV: nxt_acc = EXEC.operand;
      default:     alu_go  = 1'b0;
    endcase
  end

  // The accumulator has no path from the bus; only execution touches it.
  // source-mode load
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      acc_ff <= `CFAB_ACC_RESET;
    else if (alu_go && EXEC.src_mode)
      acc_ff <= nxt_acc;
  end

  // The accumulator must take every source-mode result and nothing else.
  property p_acc;
    @(posedge CORE_CLK) disable iff (!RST_N) (alu_go && EXEC.src_mode) |=> (acc_ff == $past(nxt_acc));
  endproperty
  a_acc: assert property (p_acc) else $error("Accumulator not loaded.");

  property p_acc_hold;
    @(posedge CORE_CLK) disable iff (!RST_N) !(alu_go && EXEC.src_mode) |=> $stable(acc_ff);
  endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("Accumulator changed without op.");

  // The sum is worked out here apart from the unit, so a broken adder shows up.
  property p_add_sum;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (EXEC.valid && EXEC.op == CFAB_OP_ADD && EXEC.src_mode) |=> (ACC == $past(acc_ff + EXEC.operand));
  endproperty
  a_add_sum: assert property (p_add_sum) else $error("Accumulator sum wrong.");

  // A move loads the operand unchanged.
  property p_mov;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (EXEC.valid && EXEC.op == CFAB_OP_MOV && EXEC.src_mode) |=> (ACC == $past(EXEC.operand));
  endproperty
  a_mov: assert property (p_mov) else $error("Accumulator move wrong.");

  ////////////////////////////////////////////////////////////////////////////////
  // Flags register.

  // Operation status bits follow every op; a flag instruction has priority over them
  // since it is the only way software alters the bank and gate bits.
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      flags_ff <= `CFAB_FLAGS_RESET;
    else
    begin
      flags_ff[`CFAB_BIT_SUPER] <= SUPER_MODE;
      if (EXEC.valid && EXEC.fop != CFAB_FOP_NONE)
      begin
        flags_ff[4:0] <= {nxt_flags[`CFAB_BIT_BANK], SUPER_MODE, nxt_flags[2:0]};
      end
      else if (alu_go)
      begin
        flags_ff[`CFAB_BIT_CARRY] <= nxt_carry;
        flags_ff[`CFAB_BIT_ZERO]  <= (nxt_acc == 8'h00);
      end
    end
  end

  // Zero and carry follow every operation that no flag instruction overrides.
  property p_zero;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (alu_go && EXEC.fop == CFAB_FOP_NONE) |=> (flags_ff[1] == ($past(nxt_acc) == 8'h00));
  endproperty
  a_zero: assert property (p_zero) else $error("Zero flag wrong.");

  property p_carry;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (alu_go && EXEC.fop == CFAB_FOP_NONE) |=> (flags_ff[2] == $past(nxt_carry));
  endproperty
  a_carry: assert property (p_carry) else $error("Carry flag wrong.");

  // Carry of an addition without the adder: a plus b overflows exactly when a exceeds the inverse of b.
  property p_add_carry;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (EXEC.valid && EXEC.op == CFAB_OP_ADD && EXEC.fop == CFAB_FOP_NONE)
        |=> (flags_ff[`CFAB_BIT_CARRY] == $past(acc_ff > ~EXEC.operand));
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("Addition carry wrong.");

  // A subtraction reports its borrow in the carry bit.
  property p_sub_borrow;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (EXEC.valid && EXEC.op == CFAB_OP_SUB && EXEC.fop == CFAB_FOP_NONE)
        |=> (flags_ff[`CFAB_BIT_CARRY] == $past(acc_ff < EXEC.operand));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("Subtraction borrow wrong.");

  // The sampled reset in the antecedent keeps this quiet on the edge that ends reset,
  // where the register is still held and cannot yet copy the mode input.
  property p_super;
    @(posedge CORE_CLK) disable iff (!RST_N) RST_N |=> (flags_ff[3] == $past(SUPER_MODE));
  endproperty
  a_super: assert property (p_super) else $error("Supervisor bit wrong.");

  // Bank and gate bits may only move under a flag instruction.
  property p_bank_hold;
    @(posedge CORE_CLK) disable iff (!RST_N)
      !(EXEC.valid && EXEC.fop != CFAB_FOP_NONE) |=> $stable(flags_ff[4]) && $stable(flags_ff[0]);
  endproperty
  a_bank_hold: assert property (p_bank_hold) else $error("Flags changed without flag op.");

  // Each flag instruction is checked against its own operator on the bank and gate bits.
  property p_flag_or;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (EXEC.valid && EXEC.fop == CFAB_FOP_OR)
        |=> (flags_ff[`CFAB_BIT_BANK] == $past(flags_ff[`CFAB_BIT_BANK] | EXEC.fmask[`CFAB_BIT_BANK]))
            && (flags_ff[`CFAB_BIT_GIE] == $past(flags_ff[`CFAB_BIT_GIE] | EXEC.fmask[`CFAB_BIT_GIE]));
  endproperty
  a_flag_or: assert property (p_flag_or) else $error("Flag set instruction wrong.");

  property p_flag_and;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (EXEC.valid && EXEC.fop == CFAB_FOP_AND)
        |=> (flags_ff[`CFAB_BIT_BANK] == $past(flags_ff[`CFAB_BIT_BANK] & EXEC.fmask[`CFAB_BIT_BANK]))
            && (flags_ff[`CFAB_BIT_GIE] == $past(flags_ff[`CFAB_BIT_GIE] & EXEC.fmask[`CFAB_BIT_GIE]));
  endproperty
  a_flag_and: assert property (p_flag_and) else $error("Flag clear instruction wrong.");

  property p_flag_xor;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (EXEC.valid && EXEC.fop == CFAB_FOP_XOR)
        |=> (flags_ff[`CFAB_BIT_BANK] == $past(flags_ff[`CFAB_BIT_BANK] ^ EXEC.fmask[`CFAB_BIT_BANK]))
            && (flags_ff[`CFAB_BIT_GIE] == $past(flags_ff[`CFAB_BIT_GIE] ^ EXEC.fmask[`CFAB_BIT_GIE]));
  endproperty
  a_flag_xor: assert property (p_flag_xor) else $error("Flag toggle instruction wrong.");

  // Bus data phase; bus writes are accepted and ignored, flags stay intact.
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ph_valid_ff <= 1'b0;
      ph_write_ff <= 1'b0;
      ph_addr_ff  <= 32'h0000_0000;
    end
    else if (HREADY)
    begin
      ph_valid_ff <= HSEL && HTRANS[1];
      ph_write_ff <= HWRITE;
      ph_addr_ff  <= HADDR;
    end
  end

  // Read data: flags and a status word with bank and gated interrupt.
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      rdata_ff <= 32'h0000_0000;
    else if (HREADY && HSEL && HTRANS[1] && !HWRITE)
    begin
      if (HADDR == `CFAB_OFF_FLAGS)
        rdata_ff <= {24'h00_0000, flags_ff};
      else if (HADDR == `CFAB_OFF_STATUS)
        rdata_ff <= {30'h0000_0000, IRQ_OUT, flags_ff[`CFAB_BIT_BANK]};
      else
        rdata_ff <= 32'h0000_0000;
    end
  end

  // A read of the flags word returns the flags as they stood at the address phase.
  property p_rdata_flags;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (ph_valid_ff && !ph_write_ff && ph_addr_ff == `CFAB_OFF_FLAGS)
        |-> (HRDATA == {24'h00_0000, $past(flags_ff)});
  endproperty
  a_rdata_flags: assert property (p_rdata_flags) else $error("Flags read-back wrong.");

  // The status word shows the selected bank and the gated interrupt.
  property p_rdata_status;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (ph_valid_ff && !ph_write_ff && ph_addr_ff == `CFAB_OFF_STATUS)
        |-> (HRDATA[0] == $past(flags_ff[`CFAB_BIT_BANK])) && (HRDATA[1] == $past(IRQ_OUT));
  endproperty
  a_rdata_status: assert property (p_rdata_status) else $error("Status read-back wrong.");

  // The accumulator has no bus address: any other read comes back as zero.
  property p_rdata_unmapped;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (ph_valid_ff && !ph_write_ff && ph_addr_ff != `CFAB_OFF_FLAGS && ph_addr_ff != `CFAB_OFF_STATUS)
        |-> (HRDATA == 32'h0000_0000);
  endproperty
  a_rdata_unmapped: assert property (p_rdata_unmapped) else $error("Unmapped read not zero.");

  assign HRDATA    = rdata_ff;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign ACC       = acc_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Register-space decode and interrupt gate.

  always_comb
  begin
    RS_SEL.bank  = flags_ff[`CFAB_BIT_BANK];
    RS_SEL.addr  = RS_ADDR;
    RS_SEL.valid = RS_VALID;
    RS_SEL.write = RS_WRITE;
  end

  assign IRQ_OUT = IRQ_REQ && flags_ff[`CFAB_BIT_GIE];

  // The gate is checked both ways, so a stuck-closed gate is caught as well as a leak.
  property p_gate;
    @(posedge CORE_CLK) disable iff (!RST_N) !flags_ff[0] |-> !IRQ_OUT;
  endproperty
  a_gate: assert property (p_gate) else $error("Interrupt passed while disabled.");

  property p_gate_open;
    @(posedge CORE_CLK) disable iff (!RST_N) (flags_ff[`CFAB_BIT_GIE] && IRQ_REQ) |-> IRQ_OUT;
  endproperty
  a_gate_open: assert property (p_gate_open) else $error("Interrupt blocked while enabled.");

  // Bank and address travel together to the register space.
  property p_bank;
    @(posedge CORE_CLK) disable iff (!RST_N) RS_SEL.bank == flags_ff[4];
  endproperty
  a_bank: assert property (p_bank) else $error("Bank select wrong.");

  property p_decode;
    @(posedge CORE_CLK) disable iff (!RST_N) RS_VALID |-> (RS_SEL.addr == RS_ADDR && RS_SEL.valid);
  endproperty
  a_decode: assert property (p_decode) else $error("Register-space decode wrong.");

endmodule : cfab_core

// ### cfab_regs.svh
// Register offsets, field positions, reset values and the writable-bit mask for the CPU flags/accumulator block.
`ifndef CFAB_REGS_SVH
`define CFAB_REGS_SVH
`define CFAB_OFF_FLAGS      32'h0000_0000
`define CFAB_OFF_STATUS     32'h0000_0004
`define CFAB_FLAGS_RESET    8'h02
`define CFAB_ACC_RESET      8'h00
`define CFAB_BIT_GIE        0
`define CFAB_BIT_ZERO       1
`define CFAB_BIT_CARRY      2
`define CFAB_BIT_SUPER      3
`define CFAB_BIT_BANK       4
`define CFAB_FLAGS_RW_MASK  8'h17
`endif

// ### cfab_pkg.sv
// Types shared by the CPU flags/accumulator block.
package cfab_pkg;
  // Operation requested by the execution unit.
  typedef enum logic [2:0]
  {
    CFAB_OP_NONE = 3'h0,
    CFAB_OP_AND  = 3'h1,
    CFAB_OP_OR   = 3'h3,
    CFAB_OP_XOR  = 3'h2,
    CFAB_OP_ADD  = 3'h6,
    CFAB_OP_SUB  = 3'h7,
    CFAB_OP_MOV  = 3'h5
  } cfab_op_e;
  // Flag-modifying logical instruction kind.
  typedef enum logic [1:0]
  {
    CFAB_FOP_NONE = 2'h0,
    CFAB_FOP_AND  = 2'h1,
    CFAB_FOP_OR   = 2'h3,
    CFAB_FOP_XOR  = 2'h2
  } cfab_fop_e;
  // One execution-unit request.
  typedef struct packed
  {
    logic      valid;
    cfab_op_e  op;
    logic      src_mode;
    logic [7:0] operand;
    cfab_fop_e fop;
    logic [7:0] fmask;
  } cfab_exec_s;
  // Register-space access decoded to a bank.
  typedef struct packed
  {
    logic       bank;
    logic [7:0] addr;
    logic       valid;
    logic       write;
  } cfab_rsel_s;
endpackage : cfab_pkg

// ### cfab_rspace_model.sv
// Register-space model that records the bank-steered address it receives.
`timescale 1ns/1ps
module cfab_rspace_model
  import cfab_pkg::*;
(
  // Clock and decoded access.
  input  wire logic       clk,
  input  wire cfab_rsel_s sel,
  // Bank and address of the last access.
  output logic [8:0]      hit_ff
);
  // Keep bank beside address so the two maps give distinct keys.
  always_ff @(posedge clk)
  begin
    if (sel.valid)
      hit_ff <= {sel.bank, sel.addr};
  end
endmodule : cfab_rspace_model

// ### test_cfab_core.sv
// Self-checking bench for the CPU flags and accumulator block.
`timescale 1ns/1ps
`include "cfab_regs.svh"
module test_cfab_core
  import cfab_pkg::*;
;
  typedef struct packed {cfab_op_e op; logic sm; logic [7:0] opd, acc, flg;} cfab_row_s;
  logic        clk = 0, rst_n = 0, hwrite = 0, rs_valid = 0, irq_req = 0, super_mode = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic        hreadyout, irq_out, hresp;
  logic [7:0]  acc, rs_addr = 0;
  logic [8:0]  hit;
  cfab_exec_s  exec = '0;
  cfab_rsel_s  rs_sel;
  int          errors = 0, total_checks = 0;
  cfab_row_s   rows [8];
  ////////////////////////////////////////////////////////////////
  // The clock toggles every 10 ns, half of its 20 ns period.
  always #10 clk = ~clk;
  cfab_core DUT (.CORE_CLK(clk), .RST_N(rst_n), .HSEL(1'b1), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .EXEC(exec), .SUPER_MODE(super_mode), .ACC(acc), .RS_VALID(rs_valid),
    .RS_ADDR(rs_addr), .RS_WRITE(1'b0), .RS_SEL(rs_sel), .IRQ_REQ(irq_req),
    .IRQ_OUT(irq_out));
  cfab_rspace_model PART (.clk(clk), .sel(rs_sel), .hit_ff(hit));
  ////////////////////////////////////////////////////////////////
  // Counts every comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // One AHB-Lite single word; waits on ready, never on a fixed count.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask : bus
  // One execution request, held for a single cycle.
  task automatic op(input cfab_exec_s e);
    @(posedge clk) exec <= e;
    @(posedge clk) exec <= '0;
    #1;
  endtask : op
  // One register-space access from the execution unit.
  task automatic rs(input logic [7:0] a);
    @(posedge clk) rs_valid <= 1'b1;
    rs_addr <= a;
    @(posedge clk) rs_valid <= 1'b0;
    #1;
  endtask : rs
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////
  // A hang is cut short well past the hundred or so cycles needed.
  initial
  begin
    #100000;
    errors++;
    report_and_stop();
  end
  // Rows chain on each other: accumulator starts at zero.
  initial
  begin
    rows[0] = '{CFAB_OP_MOV, 1'b1, 8'hff, 8'hff, 8'h00};
    rows[1] = '{CFAB_OP_ADD, 1'b1, 8'h01, 8'h00, 8'h06};
    rows[2] = '{CFAB_OP_OR,  1'b1, 8'h5a, 8'h5a, 8'h00};
    rows[3] = '{CFAB_OP_AND, 1'b1, 8'h0f, 8'h0a, 8'h00};
    rows[4] = '{CFAB_OP_XOR, 1'b1, 8'h0a, 8'h00, 8'h02};
    rows[5] = '{CFAB_OP_SUB, 1'b1, 8'h01, 8'hff, 8'h04};
    rows[6] = '{CFAB_OP_ADD, 1'b0, 8'h01, 8'hff, 8'h06};
    rows[7] = '{CFAB_OP_NONE, 1'b1, 8'h01, 8'hff, 8'h06};
    repeat (2) @(posedge clk);
    rst_n   <= 1'b1;
    irq_req <= 1'b1;
    bus(1'b0, `CFAB_OFF_FLAGS, 32'h0, rd);
    chk(rd, 32'h02);
    chk({24'h0, acc}, 32'h0);
    foreach (rows[i])
    begin
      op('{1'b1, rows[i].op, rows[i].sm, rows[i].opd, CFAB_FOP_NONE, 8'h00});
      chk({24'h0, acc}, {24'h0, rows[i].acc});
      bus(1'b0, `CFAB_OFF_FLAGS, 32'h0, rd);
      chk(rd, {24'h0, rows[i].flg});
    end
    // A bus write must leave the flags alone; only execution requests and the mode input move them.
    bus(1'b1, `CFAB_OFF_FLAGS, 32'hff, rd);
    chk({31'h0, hresp}, 32'h0);
    bus(1'b0, `CFAB_OFF_FLAGS, 32'h0, rd);
    chk(rd, 32'h06);
    op('{1'b1, CFAB_OP_NONE, 1'b0, 8'h00, CFAB_FOP_OR, 8'h11});
    chk({31'h0, irq_out}, 32'h1);
    @(posedge clk) super_mode <= 1'b1;
    bus(1'b0, `CFAB_OFF_FLAGS, 32'h0, rd);
    chk(rd, 32'h1f);
    bus(1'b0, `CFAB_OFF_STATUS, 32'h0, rd);
    chk(rd, 32'h3);
    bus(1'b0, 32'h8, 32'h0, rd);
    chk(rd, 32'h0);
    rs(8'h60);
    chk({23'h0, hit}, 32'h160);
    op('{1'b1, CFAB_OP_NONE, 1'b0, 8'h00, CFAB_FOP_XOR, 8'h10});
    rs(8'h60);
    chk({23'h0, hit}, 32'h060);
    op('{1'b1, CFAB_OP_NONE, 1'b0, 8'h00, CFAB_FOP_AND, 8'hfe});
    chk({31'h0, irq_out}, 32'h0);
    bus(1'b0, `CFAB_OFF_FLAGS, 32'h0, rd);
    chk(rd, 32'h0e);
    // Mid-run reset with the gate open, bank 1 and a loaded accumulator: all must clear.
    op('{1'b1, CFAB_OP_NONE, 1'b0, 8'h00, CFAB_FOP_OR, 8'h11});
    @(posedge clk)
    begin
      rst_n      <= 1'b0;
      super_mode <= 1'b0;
    end
    #1;
    chk({31'h0, irq_out}, 32'h0);
    chk({24'h0, acc}, 32'h0);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, `CFAB_OFF_FLAGS, 32'h0, rd);
    chk(rd, {24'h0, `CFAB_FLAGS_RESET});
    bus(1'b0, `CFAB_OFF_STATUS, 32'h0, rd);
    chk(rd, 32'h0);
    report_and_stop();
  end
endmodule : test_cfab_core
